// ### core/dcio_pkg.sv
package dcio_pkg;
  typedef enum logic [3:0] {
    DCIO_IN_NONE,
    DCIO_IN_START,
    DCIO_IN_HALT,
    DCIO_IN_RUN_LEVEL,
    DCIO_IN_FLOOD,
    DCIO_IN_PURGE_TOGGLE,
    DCIO_IN_ACK,
    DCIO_IN_ADJ_REQ,
    DCIO_IN_ADJ_INT,
    DCIO_IN_ADJ_EXT,
    DCIO_IN_RUN_TOGGLE,
    DCIO_IN_OFFSET_NULL,
    DCIO_IN_NULL_ON,
    DCIO_IN_PURGE_OPEN,
    DCIO_IN_PURGE_CLOSE,
    DCIO_IN_PROBE
  } dcio_in_fn_t;

  typedef enum logic [4:0] {
    DCIO_OUT_OPEN,
    DCIO_OUT_CLOSED,
    DCIO_OUT_THR1,
    DCIO_OUT_THR2,
    DCIO_OUT_THR3,
    DCIO_OUT_NULL,
    DCIO_OUT_READY,
    DCIO_OUT_ERROR,
    DCIO_OUT_WARN,
    DCIO_OUT_IDLE,
    DCIO_OUT_ACQ,
    DCIO_OUT_FLOODED,
    DCIO_OUT_ADJ_PROMPT,
    DCIO_OUT_BUSY,
    DCIO_OUT_EVAC,
    DCIO_OUT_PROBE,
    DCIO_OUT_TEST_OK,
    DCIO_OUT_TEST_BAD,
    DCIO_OUT_EMISSION,
    DCIO_OUT_ADJ_DONE
  } dcio_out_fn_t;

  // Device state reported by the instrument core
  typedef struct packed {
    logic standby;
    logic evacuating;
    logic measuring;
    logic adjusting;
    logic ext_adjust;
    logic leak_close_due;
    logic adj_pending;
    logic adj_done;
    logic emission_on;
    logic fault;
    logic warning;
    logic vented;
    logic probe_mode;
    logic test_pass;
    logic test_fail;
    logic [2:0] thr_exceeded;
  } dcio_status_t;

  // One-cycle command pulses towards the instrument core
  typedef struct packed {
    logic start;
    logic halt;
    logic flood;
    logic ack;
    logic adj_int;
    logic adj_ext;
    logic adj_confirm;
    logic purge_on;
    logic purge_off;
    logic null_on;
    logic null_off;
    logic probe_on;
    logic probe_off;
  } dcio_cmd_t;
endpackage : dcio_pkg

// ### core/dcio_regs.svh
// Behaviour
// - Command inputs ignored unless control location is controller, both or all.
// - Each of eight input positions takes any function; factory default per position.
// - Every input and output function selectable in inverted form.
// - Offset null input: rise switches nulling on, fall switches off.
// - Run level input: rise starts cycle, fall halts it.
// - Start rise starts; halt rise halts; halt held past delay also vents.
// - Inlet flood input rise vents the inlet.
// - Purge toggle: rise switches purge on, fall switches off.
// - Acknowledge rise clears pending error or aborts adjustment.
// - Adjust request rise: internal adjust in standby, external when measuring.
// - Adjust request fall during external adjust confirms leak closed, signal stable.
// - Adjust internal rise starts internal; adjust external rise starts external.
// - Run toggle rise starts in standby, otherwise halts.
// - Purge open rise opens purge valve; purge close rise closes it.
// - Offset null on rise enables nulling; entering standby clears it.
// - Probe mode level acted on only in standby: rise selects, fall returns.
// - Twelve relay positions take any status; all open while powered off.
// - Constant-open stays open, constant-closed stays closed.
// - Threshold outputs close only while level exceeded and measuring.
// - Status outputs: nulling, ready, idle, acquiring, inlet flooded.
// - Alarm tone driven as PWM on the tone output.
// - Error and warning outputs closed when clear, open on fault or warning.
// - Adjust prompt opens in external adjust when leak to close, else while request pending.
// - Busy during evacuate, acquiring_state_out, adjust; evacuating; probe feedback.
// - Leak test pass and fail outputs close on respective result.
`ifndef DCIO_REGS_SVH
`define DCIO_REGS_SVH
`define DCIO_NUM_IN 8
`define DCIO_NUM_OUT 12
`define DCIO_FSEL_W 4
`define DCIO_OSEL_W 5
`define DCIO_LOC_W 2
`define DCIO_LOC_LOCAL 2'h0
`define DCIO_LOC_CTRL 2'h1
`define DCIO_LOC_BOTH 2'h2
`define DCIO_LOC_ALL 2'h3
`define DCIO_CLK_HZ 50000000
`define DCIO_FLOOD_DELAY_MS 2000
`define DCIO_FLOOD_DELAY_CYC ((`DCIO_CLK_HZ / 1000) * `DCIO_FLOOD_DELAY_MS)
`define DCIO_FLOOD_CNT_W 32
`define DCIO_PWM_W 8
`define DCIO_PWM_MAX 8'hFF
`define DCIO_DEF_IN_MAP {4'h5, 4'h6, 4'h9, 4'h8, 4'h7, 4'hB, 4'h2, 4'h1}
`define DCIO_DEF_OUT_MAP {5'h00, 5'h00, 5'h00, 5'h00, 5'h0C, 5'h13, 5'h07, 5'h12, 5'h05, 5'h04, 5'h03, 5'h02}
`endif

// ### core/dcio_top.sv
`include "dcio_regs.svh"

module dcio_top (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Power and control location
  input wire logic powered_in,
  input wire logic [`DCIO_LOC_W-1:0] ctrl_loc_in,
  // Input pins and configuration
  input wire logic [`DCIO_NUM_IN-1:0] cmd_pin_in,
  input wire logic [`DCIO_NUM_IN*`DCIO_FSEL_W-1:0] in_map_in,
  input wire logic [`DCIO_NUM_IN-1:0] in_inv_in,
  input wire logic use_default_map_in,
  // Output configuration
  input wire logic [`DCIO_NUM_OUT*`DCIO_OSEL_W-1:0] out_map_in,
  input wire logic [`DCIO_NUM_OUT-1:0] out_inv_in,
  // Device state and tone
  input wire dcio_pkg::dcio_status_t status_in,
  input wire logic [`DCIO_PWM_W-1:0] tone_duty_in,
  input wire logic tone_on_in,
  // Commands
  output dcio_pkg::dcio_cmd_t cmd_out,
  output logic null_active_out,
  // Relays and tone
  output logic [`DCIO_NUM_OUT-1:0] relay_close_out,
  output logic tone_pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [`DCIO_NUM_IN-1:0] sync1;
  logic [`DCIO_NUM_IN-1:0] sync2;
  logic [`DCIO_NUM_IN-1:0] prev;
  logic [`DCIO_NUM_IN-1:0] rise;
  logic [`DCIO_NUM_IN-1:0] fall;
  logic [`DCIO_NUM_IN-1:0] lvl;
  logic [`DCIO_NUM_IN*`DCIO_FSEL_W-1:0] eff_map;
  logic allowed;
  logic halt_any;
  dcio_pkg::dcio_cmd_t [`DCIO_NUM_IN-1:0] pos_cmd;
  logic [`DCIO_NUM_IN-1:0] pos_halt;
  logic halt_at_limit;
  logic standby_d;
  logic [`DCIO_FLOOD_CNT_W-1:0] halt_cnt;
  logic halt_vented;
  logic [`DCIO_PWM_W-1:0] pwm_cnt;
  dcio_pkg::dcio_cmd_t next_cmd_any;
  logic next_null;
  logic [`DCIO_NUM_OUT-1:0] next_relay;

  assign allowed = (ctrl_loc_in == `DCIO_LOC_CTRL) || (ctrl_loc_in == `DCIO_LOC_BOTH)
                   || (ctrl_loc_in == `DCIO_LOC_ALL);
  assign eff_map = use_default_map_in ? `DCIO_DEF_IN_MAP : in_map_in;

  // Two stages; first stage is read only by the second
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (clk_en_in) begin
      sync1 <= cmd_pin_in;
      sync2 <= sync1;
    end
  end

  assign lvl = sync2 ^ in_inv_in;

  // Previous value tracks even while forbidden, so no stale edge fires on enable
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev <= '0;
    end else if (clk_en_in) begin
      prev <= lvl;
    end
  end

  assign rise = lvl & ~prev & {`DCIO_NUM_IN{allowed}};
  assign fall = ~lvl & prev & {`DCIO_NUM_IN{allowed}};

  ////////////////////////////////////////////////////////////////////////////
  // One decoder per position; one function may sit on several pins
  for (genvar i = 0; i < `DCIO_NUM_IN; i++) begin : g_in
    dcio_pkg::dcio_cmd_t next_cmd;
    logic halt_level;

    always_comb begin
      next_cmd = '0;
      halt_level = 1'b0;
      case (dcio_pkg::dcio_in_fn_t'(eff_map[i*`DCIO_FSEL_W +: `DCIO_FSEL_W]))
        dcio_pkg::DCIO_IN_START: begin
          if (rise[i]) next_cmd.start = 1'b1;
        end
        dcio_pkg::DCIO_IN_HALT: begin
          if (rise[i]) next_cmd.halt = 1'b1;
          if (lvl[i] && allowed) halt_level = 1'b1;
        end
        dcio_pkg::DCIO_IN_RUN_LEVEL: begin
          if (rise[i]) next_cmd.start = 1'b1;
          if (fall[i]) next_cmd.halt = 1'b1;
        end
        dcio_pkg::DCIO_IN_FLOOD: begin
          if (rise[i]) next_cmd.flood = 1'b1;
        end
        dcio_pkg::DCIO_IN_PURGE_TOGGLE: begin
          if (rise[i]) next_cmd.purge_on = 1'b1;
          if (fall[i]) next_cmd.purge_off = 1'b1;
        end
        dcio_pkg::DCIO_IN_ACK: begin
          if (rise[i]) next_cmd.ack = 1'b1;
        end
        dcio_pkg::DCIO_IN_ADJ_REQ: begin
          if (rise[i] && status_in.standby) next_cmd.adj_int = 1'b1;
          if (rise[i] && status_in.measuring) next_cmd.adj_ext = 1'b1;
          if (fall[i] && status_in.ext_adjust) next_cmd.adj_confirm = 1'b1;
        end
        dcio_pkg::DCIO_IN_ADJ_INT: begin
          if (rise[i]) next_cmd.adj_int = 1'b1;
        end
        dcio_pkg::DCIO_IN_ADJ_EXT: begin
          if (rise[i]) next_cmd.adj_ext = 1'b1;
        end
        dcio_pkg::DCIO_IN_RUN_TOGGLE: begin
          if (rise[i] && status_in.standby) next_cmd.start = 1'b1;
          if (rise[i] && !status_in.standby) next_cmd.halt = 1'b1;
        end
        dcio_pkg::DCIO_IN_OFFSET_NULL: begin
          if (rise[i]) next_cmd.null_on = 1'b1;
          if (fall[i]) next_cmd.null_off = 1'b1;
        end
        dcio_pkg::DCIO_IN_NULL_ON: begin
          if (rise[i]) next_cmd.null_on = 1'b1;
        end
        dcio_pkg::DCIO_IN_PURGE_OPEN: begin
          if (rise[i]) next_cmd.purge_on = 1'b1;
        end
        dcio_pkg::DCIO_IN_PURGE_CLOSE: begin
          if (rise[i]) next_cmd.purge_off = 1'b1;
        end
        dcio_pkg::DCIO_IN_PROBE: begin
          if (rise[i] && status_in.standby) next_cmd.probe_on = 1'b1;
          if (fall[i] && status_in.standby) next_cmd.probe_off = 1'b1;
        end
        default: begin
        end
      endcase
    end

    assign pos_cmd[i] = next_cmd;
    assign pos_halt[i] = halt_level;
  end

  // Same command from several positions in one cycle merges into one pulse
  always_comb begin
    next_cmd_any = '0;
    halt_any = 1'b0;
    for (int k = 0; k < `DCIO_NUM_IN; k++) begin
      next_cmd_any = next_cmd_any | pos_cmd[k];
      halt_any = halt_any | pos_halt[k];
    end
    if (halt_at_limit && !halt_vented) begin
      next_cmd_any.flood = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter saturates, so a very long hold cannot wrap and inlet_flood_input twice
  assign halt_at_limit = (halt_cnt == `DCIO_FLOOD_CNT_W'(`DCIO_FLOOD_DELAY_CYC));

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      halt_cnt <= '0;
    end else if (clk_en_in) begin
      if (!halt_any) begin
        halt_cnt <= '0;
      end else if (!halt_at_limit) begin
        halt_cnt <= halt_cnt + `DCIO_FLOOD_CNT_W'(1);
      end
    end
  end

  // One inlet_flood_input per hold; release or a forbidden location rearms it
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      halt_vented <= 1'b0;
    end else if (clk_en_in) begin
      if (!halt_any) begin
        halt_vented <= 1'b0;
      end else if (halt_at_limit) begin
        halt_vented <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_out <= '0;
    end else if (clk_en_in) begin
      cmd_out <= next_cmd_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nulling flag; standby entry wins over a same-cycle on
  always_comb begin
    next_null = null_active_out;
    if (next_cmd_any.null_on) next_null = 1'b1;
    if (next_cmd_any.null_off) next_null = 1'b0;
    if (status_in.standby && !standby_d) next_null = 1'b0;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      null_active_out <= 1'b0;
    end else if (clk_en_in) begin
      null_active_out <= next_null;
    end
  end

  // Standby seen at reset counts as an entry; nulling is off then anyway
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      standby_d <= 1'b0;
    end else if (clk_en_in) begin
      standby_d <= status_in.standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One decoder per relay; codes past the last function read open
  for (genvar j = 0; j < `DCIO_NUM_OUT; j++) begin : g_out
    logic f;

    always_comb begin
      f = 1'b0;
      case (dcio_pkg::dcio_out_fn_t'(out_map_in[j*`DCIO_OSEL_W +: `DCIO_OSEL_W]))
        dcio_pkg::DCIO_OUT_OPEN: f = 1'b0;
        dcio_pkg::DCIO_OUT_CLOSED: f = 1'b1;
        dcio_pkg::DCIO_OUT_THR1: f = status_in.thr_exceeded[0] && status_in.measuring;
        dcio_pkg::DCIO_OUT_THR2: f = status_in.thr_exceeded[1] && status_in.measuring;
        dcio_pkg::DCIO_OUT_THR3: f = status_in.thr_exceeded[2] && status_in.measuring;
        dcio_pkg::DCIO_OUT_NULL: f = null_active_out;
        dcio_pkg::DCIO_OUT_READY: f = status_in.emission_on && !status_in.fault;
        dcio_pkg::DCIO_OUT_ERROR: f = !status_in.fault;
        dcio_pkg::DCIO_OUT_WARN: f = !status_in.warning;
        dcio_pkg::DCIO_OUT_IDLE: f = status_in.standby;
        dcio_pkg::DCIO_OUT_ACQ: f = status_in.measuring;
        dcio_pkg::DCIO_OUT_FLOODED: f = status_in.vented;
        dcio_pkg::DCIO_OUT_ADJ_PROMPT: begin
          f = status_in.ext_adjust ? !status_in.leak_close_due : !status_in.adj_pending;
        end
        dcio_pkg::DCIO_OUT_BUSY: begin
          f = status_in.evacuating || status_in.measuring || status_in.adjusting;
        end
        dcio_pkg::DCIO_OUT_EVAC: f = status_in.evacuating;
        dcio_pkg::DCIO_OUT_PROBE: f = status_in.probe_mode;
        dcio_pkg::DCIO_OUT_TEST_OK: f = status_in.test_pass;
        dcio_pkg::DCIO_OUT_TEST_BAD: f = status_in.test_fail;
        dcio_pkg::DCIO_OUT_EMISSION: f = status_in.emission_on;
        dcio_pkg::DCIO_OUT_ADJ_DONE: f = status_in.adj_done;
        default: f = 1'b0;
      endcase
    end

    // Unpowered relays drop open whatever their function or polarity
    assign next_relay[j] = powered_in && (f ^ out_inv_in[j]);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      relay_close_out <= '0;
    end else if (clk_en_in) begin
      relay_close_out <= next_relay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running ramp; duty of zero gives silence
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_cnt <= '0;
    end else if (clk_en_in) begin
      pwm_cnt <= (pwm_cnt == `DCIO_PWM_MAX) ? '0 : pwm_cnt + `DCIO_PWM_W'(1);
    end
  end

  // Duty is compared every count, so a change lands mid-period
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tone_pwm_out <= 1'b0;
    end else if (clk_en_in) begin
      tone_pwm_out <= tone_on_in && (pwm_cnt < tone_duty_in);
    end
  end

endmodule // dcio_top

// ### test/dcio_plc_model.sv
module dcio_plc_model (
  // Clock and plant feedback
  input wire logic clk_in,
  input wire logic leak_shut_in,
  // Pins towards the device
  output logic [7:0] pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pins_out = 8'h00;
  task automatic put(input int i, input logic v);
    pins_out[i] = v;
  endtask
  task automatic clear();
    pins_out = 8'h00;
  endtask
  // Lowering early would confirm an adjustment on a leak still open
  task automatic confirm(input int i);
    int n;
    n = 0;
    while (!leak_shut_in && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    pins_out[i] = 1'b0;
  endtask
endmodule // dcio_plc_model

// ### test/dcio_top_sva.sv
`include "dcio_regs.svh"

module dcio_top_sva (
  // Clock and control
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic powered_in,
  input wire logic [`DCIO_LOC_W-1:0] ctrl_loc_in,
  // Output setup and state
  input wire logic [`DCIO_NUM_OUT*`DCIO_OSEL_W-1:0] out_map_in,
  input wire logic [`DCIO_NUM_OUT-1:0] out_inv_in,
  input wire dcio_pkg::dcio_status_t status_in,
  // Watched outputs
  input wire dcio_pkg::dcio_cmd_t cmd_out,
  input wire logic null_active_out,
  input wire logic [`DCIO_NUM_OUT-1:0] relay_close_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Relay 0 stands for all twelve, each behind an identical decoder
  wire logic [4:0] m0 = out_map_in[4:0];
  wire logic p = clk_en_in && powered_in;
  //////////////////////////////////////////
  power_off_open_a: assert property (clk_en_in && !powered_in |=> relay_close_out == 12'h000)
    else $error("relay closed while unpowered");
  local_refused_a: assert property (cmd_out != 13'h0000 && $past(clk_en_in) |-> $past(ctrl_loc_in) != 2'h0)
    else $error("command issued from local location");
  cmd_single_a: assert property (cmd_out.start && clk_en_in |=> !cmd_out.start)
    else $error("start pulse longer than one cycle");
  const_relay_a: assert property (p && m0 <= 5'h01 |=> relay_close_out[0] == $past(m0[0] ^ out_inv_in[0]))
    else $error("constant relay wrong");
  idle_relay_a: assert property (p && m0 == 5'h09 |=> relay_close_out[0] == $past(status_in.standby ^ out_inv_in[0]))
    else $error("idle relay wrong");
  thr_relay_a: assert property (p && m0 == 5'h02 |=> relay_close_out[0] ==
    $past((status_in.thr_exceeded[0] & status_in.measuring) ^ out_inv_in[0]))
    else $error("threshold relay wrong");
  err_relay_a: assert property (p && m0 == 5'h07 |=> relay_close_out[0] == $past(!status_in.fault ^ out_inv_in[0]))
    else $error("error relay wrong");
  null_clear_a: assert property (clk_en_in && $rose(status_in.standby) |=> !null_active_out)
    else $error("nulling kept on standby entry");
  probe_standby_a: assert property (cmd_out.probe_on || cmd_out.probe_off |-> $past(status_in.standby))
    else $error("probe change outside standby");
  cover property (cmd_out.adj_confirm);
  cover property (cmd_out.probe_on);
  cover property (!powered_in ##1 relay_close_out == 12'h000);
endmodule // dcio_top_sva

bind dcio_top dcio_top_sva sva (.ref_clk_in, .rst_in, .clk_en_in, .powered_in, .ctrl_loc_in,
  .out_map_in, .out_inv_in, .status_in, .cmd_out, .null_active_out, .relay_close_out);

// ### test/dcio_top_tb_top.sv
module dcio_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, pwr = 1'b1, dflt = 1'b0, ton = 1'b0, leak = 1'b0, en = 1'b1;
  logic [1:0] loc = 2'h1;
  logic [31:0] imap = 32'h00000000;
  logic [7:0] iinv = 8'h00, duty = 8'h00, pins;
  logic [59:0] omap = '0;
  logic [11:0] oinv = 12'h000, rel;
  dcio_pkg::dcio_status_t st = '0;
  dcio_pkg::dcio_cmd_t cmd;
  logic nul, tone;
  int error_cnt = 0, total_checks = 0;
  always #10 clk = ~clk;
  dcio_plc_model plc (.clk_in(clk), .leak_shut_in(leak), .pins_out(pins));
  dcio_top dut (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(en), .powered_in(pwr),
    .ctrl_loc_in(loc), .cmd_pin_in(pins), .in_map_in(imap), .in_inv_in(iinv),
    .use_default_map_in(dflt), .out_map_in(omap), .out_inv_in(oinv), .status_in(st),
    .tone_duty_in(duty), .tone_on_in(ton), .cmd_out(cmd), .null_active_out(nul),
    .relay_close_out(rel), .tone_pwm_out(tone));
  //////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_cmd(input dcio_pkg::dcio_cmd_t g, input dcio_pkg::dcio_cmd_t e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Pin to pulse is two sync stages plus the output register
  task automatic hit(input int i, input logic v, input dcio_pkg::dcio_cmd_t e);
    plc.put(i, v ^ iinv[i]);
    tick(3);
    chk_cmd(cmd, e);
  endtask
  function automatic logic exp_rel(input logic [4:0] f, input dcio_pkg::dcio_status_t s);
    case (f)
      5'h00: return 1'b0;
      5'h01: return 1'b1;
      5'h02, 5'h03, 5'h04: return s.thr_exceeded[f-5'h02] & s.measuring;
      5'h05: return 1'b0;
      5'h06: return s.emission_on & !s.fault;
      5'h07: return !s.fault;
      5'h08: return !s.warning;
      5'h09: return s.standby;
      5'h0A: return s.measuring;
      5'h0B: return s.vented;
      5'h0C: return s.ext_adjust ? !s.leak_close_due : !s.adj_pending;
      5'h0D: return s.evacuating | s.measuring | s.adjusting;
      5'h0E: return s.evacuating;
      5'h0F: return s.probe_mode;
      5'h10: return s.test_pass;
      5'h11: return s.test_fail;
      5'h12: return s.emission_on;
      default: return s.adj_done;
    endcase
  endfunction
  //////////////////////////////////////////
  // Nulling is still off here, so code 05 reads open
  task automatic t_relays();
    logic [4:0] off [4] = '{5'h00, 5'h02, 5'h07, 5'h09};
    logic [11:0] e;
    for (int q = 0; q < 4; q++) begin
      st = q[0] ? 18'h2A5A6 : 18'h15A59;
      oinv = q[1] ? 12'hA5A : 12'h5A5;
      for (int k = 0; k < 12; k++)
        omap[5*k +: 5] = 5'((k + off[q]) % 20);
      tick(2);
      for (int k = 0; k < 12; k++)
        e[k] = exp_rel(omap[5*k +: 5], st) ^ oinv[k];
      chk_val(16'(rel), 16'(e));
    end
    pwr = 1'b0;
    tick(2);
    chk_val(16'(rel), 16'h0000);
    pwr = 1'b1;
  endtask
  task automatic t_default();
    logic [12:0] up [8] = '{13'h1000, 13'h0800, 13'h0008, 13'h0100, 13'h0100, 13'h0080,
      13'h0200, 13'h0020};
    dflt = 1'b1;
    for (int i = 0; i < 8; i++) begin
      hit(i, 1'b1, up[i]);
      hit(i, 1'b0, (i == 2) ? 13'h0004 : (i == 7) ? 13'h0010 : 13'h0000);
    end
    dflt = 1'b0;
  endtask
  task automatic t_funcs();
    logic [12:0] up [16] = '{13'h0000, 13'h1000, 13'h0800, 13'h1000, 13'h0400, 13'h0020,
      13'h0200, 13'h0100, 13'h0100, 13'h0080, 13'h1000, 13'h0008, 13'h0008, 13'h0020,
      13'h0010, 13'h0002};
    logic [12:0] dn [16] = '{13'h0000, 13'h0000, 13'h0000, 13'h0800, 13'h0000, 13'h0010,
      13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0004, 13'h0000, 13'h0000,
      13'h0000, 13'h0001};
    int i;
    for (int f = 0; f < 16; f++) begin
      i = f % 8;
      iinv[i] = f[0];
      plc.put(i, iinv[i]);
      tick(4);
      imap[4*i +: 4] = 4'(f);
      hit(i, 1'b1, up[f]);
      if (f == 11) begin
        tick(1);
        chk_val(16'(nul), 16'h0001);
      end
      hit(i, 1'b0, dn[f]);
      imap[4*i +: 4] = 4'h0;
    end
  endtask
  task automatic t_meas();
    st = '0;
    st.measuring = 1'b1;
    iinv = 8'h00;
    plc.clear();
    tick(4);
    imap = 32'h00000FA7;
    hit(0, 1'b1, 13'h0080);
    hit(0, 1'b0, 13'h0000);
    hit(1, 1'b1, 13'h0800);
    hit(2, 1'b1, 13'h0000);
    hit(0, 1'b1, 13'h0080);
    st.ext_adjust = 1'b1;
    fork
      plc.confirm(0);
      begin
        tick(5);
        chk_cmd(cmd, 13'h0000);
        leak = 1'b1;
      end
    join
    tick(3);
    chk_cmd(cmd, 13'h0040);
  endtask
  task automatic t_loc();
    st = '0;
    st.standby = 1'b1;
    imap = 32'h00000001;
    for (int l = 0; l < 4; l++) begin
      loc = 2'(l);
      hit(0, 1'b1, (l == 0) ? 13'h0000 : 13'h1000);
      hit(0, 1'b0, 13'h0000);
    end
    loc = 2'h1;
  endtask
  // Enable low: pin edge and new polarity wait until it returns
  task automatic t_freeze();
    logic [11:0] r;
    r = rel;
    en = 1'b0;
    oinv = ~oinv;
    plc.put(0, 1'b1);
    tick(4);
    chk_cmd(cmd, 13'h0000);
    chk_val(16'(rel), 16'(r));
    en = 1'b1;
    tick(3);
    chk_cmd(cmd, 13'h1000);
    chk_val(16'(rel), 16'(r ^ 12'hFFF));
    plc.put(0, 1'b0);
    tick(3);
  endtask
  task automatic t_tone();
    logic [15:0] n;
    duty = 8'h40;
    for (int i = 0; i < 2; i++) begin
      ton = 1'(i);
      tick(4);
      n = 16'h0000;
      repeat (256) begin
        tick(1);
        n = n + 16'(tone);
      end
      chk_val(n, (i == 1) ? 16'h0040 : 16'h0000);
    end
  endtask
  //////////////////////////////////////////
  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(1);
    t_relays();
    st = '0;
    st.standby = 1'b1;
    t_default();
    t_funcs();
    t_meas();
    t_loc();
    t_freeze();
    t_tone();
    end_of_test();
  end
endmodule // dcio_top_tb_top
